// File: hw/dsau_eeprom.sv
// Separate 256-byte byte-wide store, outside the data space.
// Assumes one request per cycle; read data appears one clock after the read strobe.
`timescale 1ns/1ps
`include "dsau_map.svh"

module dsau_eeprom (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Byte access
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [7:0] rdata_o
);

   typedef struct packed {
      logic [`DSAU_EE_BYTES-1:0][7:0] mem;
      logic [7:0] rdata;
   } dsau_ee_state_t;

   dsau_ee_state_t q, d;

   // Single byte read or write, write wins the cycle
   always_comb begin
      d = q;
      if (we_i) begin
         d.mem[addr_i] = wdata_i;
      end else if (re_i) begin
         d.rdata = q.mem[addr_i];
      end
   end

   // Store held in flops, cleared at reset
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rdata_o = q.rdata;

endmodule

// File: hw/dsau_map.svh
// Constants of the data-space address unit: decode limits, pointer slots, timing.
// Assumes inclusion by bare name from the package and the design modules.
// Notes on behaviour
// - Addresses 0 to 223 decode onto internal storage.
// - First 96 registers and I/O, next 128 SRAM.
// - Every data mode except I/O direct reaches registers, I/O and SRAM; I/O direct reaches I/O only.
// - Registers 26 to 31 hold three pointers.
// - Pointers pair 27:26, 29:28 and 31:30.
// - I/O address n appears at data n+0x20.
// - Displacement adds six-bit unsigned field to pointer.
// - I/O direct takes six-bit address from instruction.
// - Data direct uses full 16-bit second word.
// - Plain indirect uses pointer unchanged.
// - Pre-decrement: decrement, use and keep pointer.
// - Post-increment: use original, increment after access.
// - Two-register mode writes result to destination.
// - Program byte read: word bits 15:1, byte bit 0.
// - Indirect jump loads PC from pointer_c.
// - Relative jump goes to PC plus offset plus one.
// - Core runs straight on system clock, no divider.
// - Fetch overlaps execute; one clock per instruction, two for SRAM, I/O and program byte accesses.
// - Register ALU operation completes in one clock.
// - Each SRAM access takes two clocks.
// - 256-byte EEPROM as separate byte space.
`ifndef DSAU_MAP_SVH
`define DSAU_MAP_SVH

`define DSAU_REG_COUNT 32
`define DSAU_IO_BASE 16'h0020
`define DSAU_SRAM_BASE 16'h0060
`define DSAU_SPACE_END 16'h00E0
`define DSAU_SRAM_BYTES 128
`define DSAU_EE_BYTES 256
`define DSAU_PTR_A_LO 5'h1A
`define DSAU_PTR_B_SEL 2'h1
`define DSAU_PTR_C_SEL 2'h2
`define DSAU_PC_W 11
`define DSAU_PC_RESET 11'h000
`define DSAU_SRAM_CYCLES 2

`endif

// File: hw/dsau_pkg.sv
// Types of the data-space address unit: operand modes, ALU operations, sequencer states.
// Assumes dsau_map.svh is reachable on the include path.
`include "dsau_map.svh"

package dsau_pkg;

   // Operand addressing modes presented by the decoder
   typedef enum logic [3:0] {
      MODE_REG2,
      MODE_IO_DIRECT,
      MODE_DATA_DIRECT,
      MODE_INDIRECT,
      MODE_PREDEC,
      MODE_POSTINC,
      MODE_DISP,
      MODE_PROG_BYTE,
      MODE_JUMP_IND,
      MODE_JUMP_REL
   } dsau_mode_t;

   // Two-register ALU operations
   typedef enum logic [2:0] {
      ALU_ADD,
      ALU_SUB,
      ALU_AND,
      ALU_OR,
      ALU_XOR,
      ALU_MOV
   } dsau_alu_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SRAM,
      ST_IO,
      ST_PROG
   } dsau_state_t;

endpackage

// File: hw/dsau_top.sv
// Data-space address unit: effective-address generation, data-space decode,
// register file, data SRAM, program-counter steering and the EEPROM byte space.
// Assumes the decoder holds an operation until it is accepted (busy_o low) and
// that I/O and program memory answer combinationally in the cycle of their strobe.
`timescale 1ns/1ps
`include "dsau_map.svh"

module dsau_top (
   // Clock and reset; the core clock is used undivided
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Operation from the decoder
   input wire logic op_valid_i,
   input wire dsau_pkg::dsau_mode_t op_mode_i,
   input wire dsau_pkg::dsau_alu_t alu_op_i,
   input wire logic op_write_i,
   input wire logic [4:0] dst_reg_i,
   input wire logic [4:0] source_reg_i,
   input wire logic [1:0] ptr_sel_i,
   input wire logic [5:0] io_addr_i,
   input wire logic [5:0] disp_i,
   input wire logic [15:0] direct_addr_i,
   input wire logic [11:0] rel_off_i,
   // Operation status
   output logic busy_o,
   output logic done_o,
   output logic [7:0] load_data_o,
   // Program counter and fetch
   output logic [`DSAU_PC_W-1:0] fetch_addr_o,
   // Program byte read
   output logic [14:0] prog_word_addr_o,
   output logic prog_re_o,
   input wire logic [15:0] prog_data_i,
   // I/O register space
   output logic [5:0] io_addr_o,
   output logic [7:0] io_wdata_o,
   output logic io_we_o,
   output logic io_re_o,
   input wire logic [7:0] io_rdata_i,
   // EEPROM byte space
   input wire logic [7:0] ee_addr_i,
   input wire logic [7:0] ee_wdata_i,
   input wire logic ee_we_i,
   input wire logic ee_re_i,
   output logic [7:0] ee_rdata_o
);

   typedef struct packed {
      logic [`DSAU_REG_COUNT-1:0][7:0] regs;
      logic [`DSAU_SRAM_BYTES-1:0][7:0] sram;
      logic [`DSAU_PC_W-1:0] pc;
      dsau_pkg::dsau_state_t state;
      logic busy;
      logic done;
      logic [7:0] load_data;
      // Operation carried across its wait state
      logic pend_wr;
      logic [4:0] pend_dst;
      logic [6:0] sram_idx;
      logic [7:0] wdata;
      logic byte_hi;
      logic ptr_upd;
      logic [4:0] ptr_lo;
      logic [15:0] ptr_val;
      // Far-side address and strobes, kept in flops so the outputs never glitch
      logic [14:0] prog_addr;
      logic prog_re;
      logic [5:0] io_addr;
      logic [7:0] io_wdata;
      logic io_we;
      logic io_re;
   } dsau_state_t;

   dsau_state_t q, d;

   // Decode results and working values
   logic [4:0] lo_idx;
   logic [15:0] ptr;
   logic [15:0] ptr_c;
   logic [15:0] ea;
   logic [15:0] new_ptr;
   logic upd;
   logic [7:0] opa;
   logic [7:0] opb;
   logic [7:0] alu_res;
   logic [15:0] io_off;
   logic [15:0] sram_off;
   logic [`DSAU_PC_W-1:0] rel_pc;

   // Pointer selection: pairs sit at 26/27, 28/29, 30/31, low byte first
   // Select 3 wraps onto r0; the decoder never issues it
   always_comb begin
      lo_idx = `DSAU_PTR_A_LO + {2'b00, ptr_sel_i, 1'b0};
      ptr = {q.regs[lo_idx + 5'h01], q.regs[lo_idx]};
      ptr_c = {q.regs[`DSAU_PTR_A_LO + 5'h05], q.regs[`DSAU_PTR_A_LO + 5'h04]};
   end

   // Effective address of the data operand and the pointer write-back
   always_comb begin
      ea = ptr;
      new_ptr = ptr;
      upd = 1'b0;
      unique case (op_mode_i)
         dsau_pkg::MODE_IO_DIRECT: ea = {10'h000, io_addr_i} + `DSAU_IO_BASE;
         dsau_pkg::MODE_DATA_DIRECT: ea = direct_addr_i;
         dsau_pkg::MODE_DISP: ea = ptr + {10'h000, disp_i};
         dsau_pkg::MODE_PREDEC: begin
            new_ptr = ptr - 16'h0001;
            ea = new_ptr;
            upd = 1'b1;
         end
         dsau_pkg::MODE_POSTINC: begin
            new_ptr = ptr + 16'h0001;
            upd = 1'b1;
         end
         default: ea = ptr;
      endcase
      // Window offsets; only their low bits are used, so the wrap is harmless
      io_off = ea - `DSAU_IO_BASE;
      sram_off = ea - `DSAU_SRAM_BASE;
   end

   // Two-operand ALU, fully combinational so read, compute and write fit one clock
   always_comb begin
      opa = q.regs[dst_reg_i];
      opb = q.regs[source_reg_i];
      unique case (alu_op_i)
         dsau_pkg::ALU_ADD: alu_res = opa + opb;
         dsau_pkg::ALU_SUB: alu_res = opa - opb;
         dsau_pkg::ALU_AND: alu_res = opa & opb;
         dsau_pkg::ALU_OR: alu_res = opa | opb;
         dsau_pkg::ALU_XOR: alu_res = opa ^ opb;
         dsau_pkg::ALU_MOV: alu_res = opb;
         default: alu_res = opb;
      endcase
   end

   // Relative target: sign-extended 12-bit offset, wraps in the 11-bit PC
   // Bit 11 of the offset is dropped: it only repeats the 11-bit wrap
   assign rel_pc = q.pc + rel_off_i[`DSAU_PC_W-1:0] + `DSAU_PC_W'(1);

   // Sequencer: accept, decode space, finish wait states
   always_comb begin
      d = q;
      d.done = 1'b0;
      d.io_we = 1'b0;
      d.io_re = 1'b0;
      d.prog_re = 1'b0;
      unique case (q.state)
         dsau_pkg::ST_IDLE: begin
            if (op_valid_i) begin
               // Fetch of the next word overlaps this execution
               d.pc = q.pc + `DSAU_PC_W'(1);
               d.pend_dst = dst_reg_i;
               d.pend_wr = op_write_i;
               d.wdata = q.regs[source_reg_i];
               d.ptr_upd = upd;
               d.ptr_lo = lo_idx;
               d.ptr_val = new_ptr;
               // Wait-state kinds raise busy so a held op_valid is not taken twice
               unique case (op_mode_i)
                  dsau_pkg::MODE_REG2: begin
                     d.regs[dst_reg_i] = alu_res;
                     d.load_data = alu_res;
                     d.done = 1'b1;
                  end
                  dsau_pkg::MODE_PROG_BYTE: begin
                     d.prog_addr = ptr_c[15:1];
                     d.byte_hi = ptr_c[0];
                     d.prog_re = 1'b1;
                     d.busy = 1'b1;
                     d.state = dsau_pkg::ST_PROG;
                  end
                  dsau_pkg::MODE_JUMP_IND: begin
                     d.pc = ptr_c[`DSAU_PC_W-1:0];
                     d.done = 1'b1;
                  end
                  dsau_pkg::MODE_JUMP_REL: begin
                     d.pc = rel_pc;
                     d.done = 1'b1;
                  end
                  default: begin
                     // Data access: every mode lands on the one space decoder
                     if (ea < `DSAU_IO_BASE) begin
                        // Pointer step first, so a data write to the pointer wins
                        if (upd) begin
                           d.regs[lo_idx] = new_ptr[7:0];
                           d.regs[lo_idx + 5'h01] = new_ptr[15:8];
                        end
                        if (op_write_i) begin
                           d.regs[ea[4:0]] = q.regs[source_reg_i];
                        end else begin
                           d.regs[dst_reg_i] = q.regs[ea[4:0]];
                           d.load_data = q.regs[ea[4:0]];
                        end
                        d.done = 1'b1;
                     end else if (ea < `DSAU_SRAM_BASE) begin
                        // Strobe leaves from a flop; the answer is taken at the next edge
                        d.io_addr = io_off[5:0];
                        d.io_wdata = q.regs[source_reg_i];
                        d.io_we = op_write_i;
                        d.io_re = !op_write_i;
                        d.busy = 1'b1;
                        d.state = dsau_pkg::ST_IO;
                     end else if (ea < `DSAU_SPACE_END) begin
                        // First of the two SRAM clocks latches the address
                        d.sram_idx = sram_off[6:0];
                        d.busy = 1'b1;
                        d.state = dsau_pkg::ST_SRAM;
                     end else begin
                        // Outside the space: no storage touched, loads see zero
                        if (upd) begin
                           d.regs[lo_idx] = new_ptr[7:0];
                           d.regs[lo_idx + 5'h01] = new_ptr[15:8];
                        end
                        if (!op_write_i) begin
                           d.regs[dst_reg_i] = 8'h00;
                           d.load_data = 8'h00;
                        end
                        d.done = 1'b1;
                     end
                  end
               endcase
            end
         end
         dsau_pkg::ST_SRAM: begin
            // Pointer step lands with the access so post-increment follows it
            if (q.ptr_upd) begin
               d.regs[q.ptr_lo] = q.ptr_val[7:0];
               d.regs[q.ptr_lo + 5'h01] = q.ptr_val[15:8];
            end
            // Second clock of the access: the array moves at the latched index
            if (q.pend_wr) begin
               d.sram[q.sram_idx] = q.wdata;
            end else begin
               d.regs[q.pend_dst] = q.sram[q.sram_idx];
               d.load_data = q.sram[q.sram_idx];
            end
            d.done = 1'b1;
            d.busy = 1'b0;
            d.state = dsau_pkg::ST_IDLE;
         end
         dsau_pkg::ST_IO: begin
            // I/O answers in its strobe cycle, so its data is taken here
            if (q.ptr_upd) begin
               d.regs[q.ptr_lo] = q.ptr_val[7:0];
               d.regs[q.ptr_lo + 5'h01] = q.ptr_val[15:8];
            end
            if (!q.pend_wr) begin
               d.regs[q.pend_dst] = io_rdata_i;
               d.load_data = io_rdata_i;
            end
            d.done = 1'b1;
            d.busy = 1'b0;
            d.state = dsau_pkg::ST_IDLE;
         end
         dsau_pkg::ST_PROG: begin
            // Low byte on an even address, high byte on an odd one
            d.load_data = q.byte_hi ? prog_data_i[15:8] : prog_data_i[7:0];
            d.regs[q.pend_dst] = d.load_data;
            d.done = 1'b1;
            d.busy = 1'b0;
            d.state = dsau_pkg::ST_IDLE;
         end
      endcase
   end

   // All state on the undivided core clock
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Separate byte store, not in the data space
   // It shares no decode with the data space, so no data address can alias it
   dsau_eeprom u_eeprom (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .addr_i(ee_addr_i),
      .wdata_i(ee_wdata_i),
      .we_i(ee_we_i),
      .re_i(ee_re_i),
      .rdata_o(ee_rdata_o)
   );

   // Outputs straight from the state flops
   // The byte store's read data leaves from that module's own flop
   assign busy_o = q.busy;
   assign done_o = q.done;
   assign load_data_o = q.load_data;
   assign fetch_addr_o = q.pc;
   assign prog_word_addr_o = q.prog_addr;
   assign prog_re_o = q.prog_re;
   assign io_addr_o = q.io_addr;
   assign io_wdata_o = q.io_wdata;
   assign io_we_o = q.io_we;
   assign io_re_o = q.io_re;

endmodule

// File: verification/dsau_far_model.sv
// Far-side model: I/O register bank and program memory answering in the strobe cycle.
// Assumes the unit drives address and strobe from registers just after the clock edge.
`timescale 1ns/1ps

module dsau_far_model (
   // Clock
   input wire logic core_clk_i,
   // I/O register space
   input wire logic [5:0] io_addr_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic io_we_i,
   input wire logic io_re_i,
   output logic [7:0] io_rdata_o,
   // Program memory
   input wire logic [14:0] prog_word_addr_i,
   input wire logic prog_re_i,
   output logic [15:0] prog_data_o
);
   logic [7:0] io_q [64];
   logic [15:0] word;
   initial foreach (io_q[i]) io_q[i] = 8'h00;
   // Writes land at the edge that closes the strobe cycle
   always @(posedge core_clk_i) begin
      if (io_we_i) begin
         io_q[io_addr_i] <= io_wdata_i;
      end
   end
   // Outside a strobe the lines show the inverse, so a late sample never matches
   always_comb begin
      word = {prog_word_addr_i[7:0], ~prog_word_addr_i[7:0]};
      io_rdata_o = io_re_i ? io_q[io_addr_i] : ~io_q[io_addr_i];
      prog_data_o = prog_re_i ? word : ~word;
   end
endmodule

// File: verification/dsau_top_props.sv
// Checker of the data-space address unit: decode, wait states and program-counter steps.
// Assumes it is bound onto dsau_top and sees that module's ports only.
`timescale 1ns/1ps
`include "dsau_map.svh"

module dsau_top_props (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Operation inputs
   input wire logic op_valid_i,
   input wire dsau_pkg::dsau_mode_t op_mode_i,
   input wire logic op_write_i,
   input wire logic [5:0] io_addr_i,
   input wire logic [15:0] direct_addr_i,
   input wire logic [11:0] rel_off_i,
   // Design outputs
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic [7:0] load_data_o,
   input wire logic [`DSAU_PC_W-1:0] fetch_addr_o,
   input wire logic prog_re_o,
   input wire logic [5:0] io_addr_o,
   input wire logic io_we_o,
   input wire logic io_re_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   // Accepted operation, and accepted direct data access
   logic acc;
   logic dd;
   assign acc = op_valid_i && !busy_o;
   assign dd = acc && op_mode_i == dsau_pkg::MODE_DATA_DIRECT;

   reg_one_cycle_a: assert property (
      acc && op_mode_i == dsau_pkg::MODE_REG2 |=> done_o && !busy_o)
      else $error("register operation not done in one cycle");
   pc_step_a: assert property (
      acc && op_mode_i == dsau_pkg::MODE_REG2
      |=> fetch_addr_o == `DSAU_PC_W'($past(fetch_addr_o) + 11'h001))
      else $error("program counter did not step by one");
   rel_jump_a: assert property (
      acc && op_mode_i == dsau_pkg::MODE_JUMP_REL |=> fetch_addr_o ==
      `DSAU_PC_W'($past(fetch_addr_o) + $past(rel_off_i[10:0]) + 11'h001))
      else $error("relative jump target wrong");
   prog_wait_a: assert property (
      acc && op_mode_i == dsau_pkg::MODE_PROG_BYTE |=> busy_o && prog_re_o ##1 done_o)
      else $error("program byte read timing wrong");
   sram_wait_a: assert property (
      dd && direct_addr_i inside {[16'h0060:16'h00DF]} |=> busy_o && !done_o ##1 done_o)
      else $error("data memory access not two cycles");
   io_alias_a: assert property (
      dd && direct_addr_i inside {[16'h0020:16'h005F]} |=> (io_re_o || io_we_o)
      && io_addr_o == 6'($past(direct_addr_i[5:0]) - 6'h20))
      else $error("data address not mapped onto I/O address");
   io_direct_a: assert property (
      acc && op_mode_i == dsau_pkg::MODE_IO_DIRECT
      |=> io_re_o == !$past(op_write_i) && io_we_o == $past(op_write_i)
      && io_addr_o == $past(io_addr_i))
      else $error("I/O direct address or strobe wrong");
   unmapped_a: assert property (
      dd && direct_addr_i >= 16'h00E0 |=> done_o && !io_we_o && !io_re_o
      && ($past(op_write_i) || load_data_o == 8'h00))
      else $error("unmapped address not empty");
   regspace_a: assert property (
      dd && direct_addr_i < 16'h0020 |=> done_o && !io_re_o && !io_we_o)
      else $error("register space access left the register file");

   // Main scenarios
   cover property (acc && op_mode_i == dsau_pkg::MODE_POSTINC);
   cover property (acc && op_mode_i == dsau_pkg::MODE_DISP);
   cover property (dd && direct_addr_i >= 16'h00E0);
endmodule

bind dsau_top dsau_top_props PROPS (.core_clk_i, .rst_n_i, .op_valid_i, .op_mode_i,
   .op_write_i, .io_addr_i, .direct_addr_i, .rel_off_i, .busy_o, .done_o, .load_data_o,
   .fetch_addr_o, .prog_re_o, .io_addr_o, .io_we_o, .io_re_o);

// File: verification/dsau_top_tb_top.sv
// Testbench of the data-space address unit: six directed tasks covering the addressing modes and the EEPROM byte space.
// Assumes the far-side model answers I/O and program reads in the strobe cycle.
`timescale 1ns/1ps
`include "dsau_map.svh"

module dsau_top_tb_top;
   // Design ports
   logic core_clk_i, rst_n_i, op_valid_i, op_write_i, busy_o, done_o, prog_re_o;
   logic io_we_o, io_re_o, ee_we_i, ee_re_i;
   dsau_pkg::dsau_mode_t op_mode_i;
   dsau_pkg::dsau_alu_t alu_op_i;
   logic [4:0] dst_reg_i, source_reg_i;
   logic [1:0] ptr_sel_i;
   logic [5:0] io_addr_i, disp_i, io_addr_o;
   logic [15:0] direct_addr_i, prog_data_i;
   logic [11:0] rel_off_i;
   logic [7:0] load_data_o, io_wdata_o, io_rdata_i, ee_addr_i, ee_wdata_i, ee_rdata_o;
   logic [`DSAU_PC_W-1:0] fetch_addr_o, pc, pc_before;
   logic [14:0] prog_word_addr_o;
   logic [7:0] alu_exp [6] = '{8'hE1, 8'h69, 8'h24, 8'hBD, 8'h99, 8'h3C};
   int fail_count, samples_checked, lat;

   dsau_top DUT (.core_clk_i, .rst_n_i, .op_valid_i, .op_mode_i, .alu_op_i, .op_write_i,
      .dst_reg_i, .source_reg_i, .ptr_sel_i, .io_addr_i, .disp_i, .direct_addr_i, .rel_off_i,
      .busy_o, .done_o, .load_data_o, .fetch_addr_o, .prog_word_addr_o, .prog_re_o,
      .prog_data_i, .io_addr_o, .io_wdata_o, .io_we_o, .io_re_o, .io_rdata_i, .ee_addr_i,
      .ee_wdata_i, .ee_we_i, .ee_re_i, .ee_rdata_o);
   dsau_far_model FAR (.core_clk_i, .io_addr_i(io_addr_o), .io_wdata_i(io_wdata_o),
      .io_we_i(io_we_o), .io_re_i(io_re_o), .io_rdata_o(io_rdata_i),
      .prog_word_addr_i(prog_word_addr_o), .prog_re_i(prog_re_o), .prog_data_o(prog_data_i));

   // 100 MHz clock
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One operation, held for a single accepting edge; lat counts cycles to done
   task automatic op(input dsau_pkg::dsau_mode_t m, input logic wr, input logic [4:0] d,
                     input logic [4:0] s, input logic [1:0] p, input logic [15:0] a);
      @(negedge core_clk_i);
      op_valid_i = 1'b1;
      op_mode_i = m;
      op_write_i = wr;
      dst_reg_i = d;
      source_reg_i = s;
      ptr_sel_i = p;
      direct_addr_i = a;
      io_addr_i = a[5:0];
      disp_i = a[5:0];
      rel_off_i = a[11:0];
      @(negedge core_clk_i);
      op_valid_i = 1'b0;
      lat = 1;
      while (done_o !== 1'b1 && lat < 5) begin
         @(negedge core_clk_i);
         lat++;
      end
      chk({15'h0000, done_o}, 16'h0001);
      pc = pc + 11'h001;
   endtask

   // Register load through the spare I/O slot 0x3F
   task automatic setreg(input logic [4:0] r, input logic [7:0] v);
      FAR.io_q[63] = v;
      op(dsau_pkg::MODE_IO_DIRECT, 1'b0, r, 5'h00, 2'h0, 16'h003F);
   endtask

   task automatic t_alu;
      setreg(5'h02, 8'h3C);
      for (int k = 0; k < 6; k++) begin
         setreg(5'h01, 8'hA5);
         alu_op_i = dsau_pkg::dsau_alu_t'(k);
         op(dsau_pkg::MODE_REG2, 1'b0, 5'h01, 5'h02, 2'h0, 16'h0000);
         chk(16'(lat), 16'h0001);
         chk(load_data_o, alu_exp[k]);
      end
      op(dsau_pkg::MODE_DATA_DIRECT, 1'b0, 5'h03, 5'h00, 2'h0, 16'h0001);
      chk(load_data_o, 8'h3C);
   endtask

   task automatic t_map;
      FAR.io_q[5] = 8'h77;
      op(dsau_pkg::MODE_DATA_DIRECT, 1'b0, 5'h04, 5'h00, 2'h0, 16'h0025);
      chk(16'(lat), 16'h0002);
      chk(load_data_o, 8'h77);
      op(dsau_pkg::MODE_DATA_DIRECT, 1'b1, 5'h00, 5'h03, 2'h0, 16'h00DF);
      chk(16'(lat), 16'h0002);
      op(dsau_pkg::MODE_DATA_DIRECT, 1'b0, 5'h05, 5'h00, 2'h0, 16'h00DF);
      chk(load_data_o, 8'h3C);
      op(dsau_pkg::MODE_DATA_DIRECT, 1'b1, 5'h00, 5'h03, 2'h0, 16'h00E0);
      op(dsau_pkg::MODE_DATA_DIRECT, 1'b0, 5'h06, 5'h00, 2'h0, 16'h00E0);
      chk(load_data_o, 8'h00);
      op(dsau_pkg::MODE_DATA_DIRECT, 1'b0, 5'h06, 5'h00, 2'h0, 16'h0060);
      chk(load_data_o, 8'h00);
      op(dsau_pkg::MODE_DATA_DIRECT, 1'b0, 5'h07, 5'h00, 2'h0, 16'h0004);
      chk(load_data_o, 8'h77);
      chk(16'(lat), 16'h0001);
      op(dsau_pkg::MODE_IO_DIRECT, 1'b1, 5'h00, 5'h07, 2'h0, 16'h0010);
      chk(io_wdata_o, 8'h77);
      chk(FAR.io_q[16], 8'h77);
   endtask

   task automatic t_ptr;
      setreg(5'h1B, 8'h00);
      setreg(5'h1A, 8'h60);
      setreg(5'h01, 8'h5A);
      setreg(5'h02, 8'hC3);
      op(dsau_pkg::MODE_POSTINC, 1'b1, 5'h00, 5'h01, 2'h0, 16'h0000);
      op(dsau_pkg::MODE_POSTINC, 1'b1, 5'h00, 5'h02, 2'h0, 16'h0000);
      op(dsau_pkg::MODE_DATA_DIRECT, 1'b0, 5'h08, 5'h00, 2'h0, 16'h001A);
      chk(load_data_o, 8'h62);
      op(dsau_pkg::MODE_INDIRECT, 1'b0, 5'h09, 5'h00, 2'h0, 16'h0000);
      chk(load_data_o, 8'h00);
      op(dsau_pkg::MODE_PREDEC, 1'b0, 5'h09, 5'h00, 2'h0, 16'h0000);
      chk(load_data_o, 8'hC3);
      op(dsau_pkg::MODE_PREDEC, 1'b0, 5'h09, 5'h00, 2'h0, 16'h0000);
      chk(load_data_o, 8'h5A);
      setreg(5'h1D, 8'h00);
      setreg(5'h1C, 8'h21);
      op(dsau_pkg::MODE_DISP, 1'b0, 5'h0A, 5'h00, 2'h1, 16'h003F);
      chk(load_data_o, 8'h5A);
      setreg(5'h1F, 8'h00);
      setreg(5'h1E, 8'h25);
      FAR.io_q[5] = 8'h4E;
      op(dsau_pkg::MODE_INDIRECT, 1'b0, 5'h0A, 5'h00, 2'h2, 16'h0000);
      chk(load_data_o, 8'h4E);
   endtask

   task automatic t_prog;
      setreg(5'h1E, 8'h13);
      op(dsau_pkg::MODE_PROG_BYTE, 1'b0, 5'h0B, 5'h00, 2'h2, 16'h0000);
      chk(prog_word_addr_o, 15'h0009);
      chk(load_data_o, 8'h09);
      setreg(5'h1E, 8'h12);
      op(dsau_pkg::MODE_PROG_BYTE, 1'b0, 5'h0B, 5'h00, 2'h2, 16'h0000);
      chk(load_data_o, 8'hF6);
   endtask

   task automatic t_jump;
      setreg(5'h1F, 8'h01);
      setreg(5'h1E, 8'h23);
      op(dsau_pkg::MODE_JUMP_IND, 1'b0, 5'h00, 5'h00, 2'h2, 16'h0000);
      pc = 11'h123;
      chk(fetch_addr_o, pc);
      op(dsau_pkg::MODE_REG2, 1'b0, 5'h0C, 5'h0C, 2'h0, 16'h0000);
      chk(fetch_addr_o, pc);
      foreach (alu_exp[i]) begin
         pc_before = pc;
         op(dsau_pkg::MODE_JUMP_REL, 1'b0, 5'h00, 5'h00, 2'h0, {4'h0, alu_exp[i]} ^ 16'h0800);
         pc = pc_before + {3'h0, alu_exp[i]} + 11'h001;
         chk(fetch_addr_o, pc);
      end
   endtask

   task automatic t_ee;
      @(negedge core_clk_i);
      ee_we_i = 1'b1;
      ee_addr_i = 8'hFF;
      ee_wdata_i = 8'hC3;
      @(negedge core_clk_i);
      ee_addr_i = 8'h00;
      ee_wdata_i = 8'h3C;
      @(negedge core_clk_i);
      ee_we_i = 1'b0;
      ee_re_i = 1'b1;
      ee_addr_i = 8'hFF;
      @(negedge core_clk_i);
      chk(ee_rdata_o, 8'hC3);
      ee_addr_i = 8'h00;
      @(negedge core_clk_i);
      chk(ee_rdata_o, 8'h3C);
      ee_re_i = 1'b0;
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Watchdog: the whole sequence needs well under 2 us
   initial begin
      #50000;
      fail_count++;
      summarize();
   end

   // Reset, then the scenarios in turn
   initial begin
      fail_count = 0;
      samples_checked = 0;
      pc = '0;
      rst_n_i = 1'b0;
      op_mode_i = dsau_pkg::MODE_REG2;
      alu_op_i = dsau_pkg::ALU_ADD;
      {op_valid_i, op_write_i, ee_we_i, ee_re_i, dst_reg_i, source_reg_i, ptr_sel_i} = '0;
      {io_addr_i, disp_i, direct_addr_i, rel_off_i, ee_addr_i, ee_wdata_i} = '0;
      repeat (4) @(posedge core_clk_i);
      @(negedge core_clk_i);
      rst_n_i = 1'b1;
      t_alu();
      t_map();
      t_ptr();
      t_prog();
      t_jump();
      t_ee();
      summarize();
   end
endmodule
